// ---- design/ail_pkg.sv ----
package ail_pkg;

    // register offsets, byte addresses on the processor port
    localparam logic [5:0] AIL_REALTIME_ALARM_STATUS    = 6'h00;
    localparam logic [5:0] AIL_LATCHED_ALARM_STATUS     = 6'h16;
    localparam logic [5:0] AIL_LOOPBACK_REQUEST_ALL     = 6'h25;
    localparam logic [5:0] AIL_LOOPBACK_REQUEST_DS3     = 6'h26;
    localparam logic [5:0] AIL_LOOPBACK_REQUEST_MORE    = 6'h27;
    localparam logic [5:0] AIL_FRAME_ERROR_REQUEST      = 6'h28;
    localparam logic [5:0] AIL_DS3_STATUS_REQUEST       = 6'h29;
    localparam logic [5:0] AIL_DS2_FRAME_LOSS_REQUEST   = 6'h2a;
    localparam logic [5:0] AIL_COUNTER_SATURATION_REQ   = 6'h2b;
    localparam logic [5:0] AIL_DATALINK_REQUEST         = 6'h2c;
    localparam logic [5:0] AIL_REQUEST_MASK_BASE        = 6'h2e;
    localparam logic [5:0] AIL_DATALINK_RX_FIFO_PORT    = 6'h38;
    localparam logic [5:0] AIL_DATALINK_RX_MSG_LENGTH   = 6'h39;
    localparam logic [5:0] AIL_DATALINK_RX_FIFO_DEPTH   = 6'h3a;
    localparam logic [5:0] AIL_EDGE_CONTROL             = 6'h3e;

    // request bank layout: banks 0..7 sit at 0x25..0x2c, masks at 0x2e..0x35
    localparam int         AIL_NUM_BANKS                = 8;
    localparam int         AIL_COND_BANKS               = 6;
    localparam int         AIL_DS3_BANK                 = 4;
    localparam int         AIL_DATALINK_BANK            = 7;
    localparam logic [2:0] AIL_BANK_TOP                 = 3'h7;

    // edge control fields
    localparam int         AIL_RISE_BIT                 = 0;
    localparam int         AIL_FALL_BIT                 = 1;
    localparam int         AIL_WIDE_BIT                 = 2;

    // reset values
    localparam logic [7:0] AIL_REQ_RESET                = 8'h00;
    localparam logic [7:0] AIL_MASK_RESET               = 8'h00;
    localparam logic [1:0] AIL_EDGE_RESET               = 2'h0;
    localparam logic [7:0] AIL_RDATA_RESET              = 8'h00;

    typedef logic [7:0] ail_byte_t;

endpackage

// ---- design/ail_req_if.sv ----
`timescale 1ns/10ps
interface ail_req_if (
    input wire logic ref_clk,
    input wire logic sys_rst
);
    logic [7:0] status;
    logic       rise_en;
    logic       fall_en;
    logic       entry_only;
    logic [7:0] set_vec;
    logic       rd_clr;
    logic [7:0] mask;
    logic [7:0] req;
    logic       pend;

    modport det  (input ref_clk, sys_rst, status, rise_en, fall_en, entry_only, output set_vec);
    modport bank (input ref_clk, sys_rst, set_vec, rd_clr, mask, output req, pend);
    modport ctl  (output status, rise_en, fall_en, entry_only, rd_clr, mask, input req, pend, set_vec);
endinterface

// ---- design/ail_edge.sv ----
`timescale 1ns/10ps
module ail_edge
    import ail_pkg::*;
(
    ail_req_if.det p
);
    logic [7:0] prev_r;
    logic       armed_r;
    logic [7:0] rise;
    logic [7:0] fall;

    // first sample after reset only seeds the history, so no false edge
    always_ff @(posedge p.ref_clk) begin
        if (p.sys_rst) begin
            prev_r  <= AIL_REQ_RESET;
            armed_r <= 1'b0;
        end else begin
            prev_r  <= p.status;
            armed_r <= 1'b1;
        end
    end

    assign rise = p.status & ~prev_r;
    assign fall = ~p.status & prev_r;

    always_comb begin
        if (!armed_r) begin
            p.set_vec = 8'h00;
        end else if (p.entry_only) begin
            p.set_vec = rise;
        end else begin
            p.set_vec = (p.rise_en ? rise : 8'h00)
                      | (p.fall_en ? fall : 8'h00);
        end
    end

    default clocking @(posedge p.ref_clk); endclocking
    default disable iff (p.sys_rst);

    edge_off_quiet_a: assert property (!p.entry_only && !p.rise_en && !p.fall_en |-> p.set_vec == 8'h00)
        else $error("request set with both edge controls off");
    entry_no_fall_a: assert property (p.entry_only |-> (p.set_vec & ~p.status) == 8'h00)
        else $error("entry-only bank set on exit");
endmodule

// ---- design/ail_reqbank.sv ----
`timescale 1ns/10ps
module ail_reqbank
    import ail_pkg::*;
(
    ail_req_if.bank p
);
    logic [7:0] req_r;

    // set wins over the clearing read, so a coinciding event survives
    always_ff @(posedge p.ref_clk) begin
        if (p.sys_rst) begin
            req_r <= AIL_REQ_RESET;
        end else begin
            req_r <= (req_r & ~{8{p.rd_clr}}) | p.set_vec;
        end
    end

    assign p.req  = req_r;
    assign p.pend = |(req_r & p.mask);

    default clocking @(posedge p.ref_clk); endclocking
    default disable iff (p.sys_rst);

    sticky_hold_a: assert property (!p.rd_clr |=> (p.req & $past(p.req)) == $past(p.req))
        else $error("request bit dropped without a read");
    read_clear_a: assert property (p.rd_clr |=> p.req == $past(p.set_vec))
        else $error("read did not clear the request bits");
    set_wins_a: assert property (p.rd_clr && p.set_vec != 8'h00 |=> (p.req & $past(p.set_vec)) == $past(p.set_vec))
        else $error("event lost under clearing read");
    latch_set_a: assert property ((p.set_vec != 8'h00) |=> (p.req & $past(p.set_vec)) == $past(p.set_vec))
        else $error("event did not latch");
    clear_race_c: cover property (p.rd_clr && p.set_vec != 8'h00);
endmodule

// ---- design/ail_top.sv ----
`timescale 1ns/10ps
module ail_top
    import ail_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             sys_rst,
    input  wire logic [5:0]       cpu_addr,
    input  wire logic             cpu_rd,
    input  wire logic             cpu_wr,
    input  wire logic [7:0]       cpu_wdata,
    output logic      [7:0]       cpu_rdata,
    output logic                  int_req,
    input  wire logic [7:0]       alarm_rt,
    input  wire logic [5:0][7:0]  cond_rt,
    input  wire logic [7:0]       path_maint_link_rt,
    input  wire logic [7:0]       dl_fifo_data,
    input  wire logic [7:0]       dl_msg_length,
    input  wire logic [7:0]       dl_fifo_depth,
    output logic                  dl_fifo_pop,
    input  wire logic             compat_sel,
    output logic                  counter_wide
);

    ////////////////////////////////////////////////////////////////////////////
    // control registers

    logic [1:0]                   edge_ctl_r;
    logic [AIL_NUM_BANKS-1:0][7:0] mask_r;
    logic [7:0]                   latched_r;
    logic [7:0]                   rdata_r;
    logic [7:0]                   rdata_nxt;
    logic                         int_req_r;
    logic                         wide_r;
    logic [AIL_NUM_BANKS-1:0]     bank_hit;
    logic [AIL_NUM_BANKS-1:0]     mask_hit;
    logic [AIL_NUM_BANKS-1:0]     bank_pend;
    logic [AIL_NUM_BANKS-1:0][7:0] bank_req;
    logic [AIL_NUM_BANKS-1:0][7:0] bank_status;
    logic                         rd_latched;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            edge_ctl_r <= AIL_EDGE_RESET;
        end else if (cpu_wr && cpu_addr == AIL_EDGE_CONTROL) begin
            edge_ctl_r <= cpu_wdata[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mask_r <= {AIL_NUM_BANKS{AIL_MASK_RESET}};
        end else begin
            for (int i = 0; i < AIL_NUM_BANKS; i++) begin
                if (cpu_wr && mask_hit[i]) begin
                    mask_r[i] <= cpu_wdata;
                end
            end
        end
    end

    // counter width follows the compatibility strap continuously
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wide_r <= 1'b0;
        end else begin
            wide_r <= ~compat_sel;
        end
    end

    assign counter_wide = wide_r;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    always_comb begin
        for (int i = 0; i < AIL_NUM_BANKS; i++) begin
            bank_hit[i] = (cpu_addr == AIL_LOOPBACK_REQUEST_ALL + 6'(i));
            mask_hit[i] = (cpu_addr == AIL_REQUEST_MASK_BASE + 6'(i));
        end
    end

    assign rd_latched  = cpu_rd && (cpu_addr == AIL_LATCHED_ALARM_STATUS);
    assign dl_fifo_pop = cpu_rd && (cpu_addr == AIL_DATALINK_RX_FIFO_PORT);

    ////////////////////////////////////////////////////////////////////////////
    // status sources per bank

    // the ds3 bank watches the live alarm inputs, never the latched copy
    always_comb begin
        bank_status[0]                 = cond_rt[0];
        bank_status[1]                 = cond_rt[1];
        bank_status[2]                 = cond_rt[2];
        bank_status[3]                 = cond_rt[3];
        bank_status[AIL_DS3_BANK]      = alarm_rt;
        bank_status[5]                 = cond_rt[4];
        bank_status[6]                 = cond_rt[5];
        bank_status[AIL_DATALINK_BANK] = path_maint_link_rt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // request banks

    for (genvar g = 0; g < AIL_NUM_BANKS; g++) begin : bank_g
        ail_req_if u_if (
            .ref_clk (ref_clk),
            .sys_rst (sys_rst)
        );

        assign u_if.status     = bank_status[g];
        assign u_if.rise_en    = edge_ctl_r[AIL_RISE_BIT];
        assign u_if.fall_en    = edge_ctl_r[AIL_FALL_BIT];
        assign u_if.entry_only = (g == AIL_DATALINK_BANK);
        assign u_if.rd_clr     = cpu_rd && bank_hit[g];
        assign u_if.mask       = mask_r[g];
        assign bank_req[g]     = u_if.req;
        assign bank_pend[g]    = u_if.pend;

        ail_edge u_edge (
            .p (u_if)
        );

        ail_reqbank u_bank (
            .p (u_if)
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // latched alarm copy, clear on read; set wins over the read

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            latched_r <= AIL_REQ_RESET;
        end else begin
            latched_r <= (latched_r & ~{8{rd_latched}}) | alarm_rt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt output

    // registered so the lead never glitches while banks update
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            int_req_r <= 1'b0;
        end else begin
            int_req_r <= |bank_pend;
        end
    end

    assign int_req = int_req_r;

    ////////////////////////////////////////////////////////////////////////////
    // read data

    always_comb begin
        rdata_nxt = 8'h00;
        if (cpu_addr == AIL_REALTIME_ALARM_STATUS) begin
            rdata_nxt = alarm_rt;
        end else if (cpu_addr == AIL_LATCHED_ALARM_STATUS) begin
            rdata_nxt = latched_r;
        end else if (cpu_addr == AIL_DATALINK_RX_FIFO_PORT) begin
            rdata_nxt = dl_fifo_data;
        end else if (cpu_addr == AIL_DATALINK_RX_MSG_LENGTH) begin
            rdata_nxt = dl_msg_length;
        end else if (cpu_addr == AIL_DATALINK_RX_FIFO_DEPTH) begin
            rdata_nxt = dl_fifo_depth;
        end else if (cpu_addr == AIL_EDGE_CONTROL) begin
            rdata_nxt = {5'h00, wide_r, edge_ctl_r};
        end else begin
            for (int i = 0; i < AIL_NUM_BANKS; i++) begin
                if (bank_hit[i]) begin
                    rdata_nxt = bank_req[i];
                end
                if (mask_hit[i]) begin
                    rdata_nxt = mask_r[i];
                end
            end
        end
    end

    // data is captured on the same edge that clears, so the read sees the old bits
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_r <= AIL_RDATA_RESET;
        end else if (cpu_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign cpu_rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // check helpers

    // private status history, so a stuck history inside a bank cannot hide behind itself
    logic [AIL_NUM_BANKS-1:0][7:0] chk_prev_r;
    logic                          chk_armed_r;
    logic [AIL_NUM_BANKS-1:0][7:0] chk_rise;
    logic [AIL_NUM_BANKS-1:0][7:0] chk_fall;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            chk_prev_r  <= {AIL_NUM_BANKS{AIL_REQ_RESET}};
            chk_armed_r <= 1'b0;
        end else begin
            chk_prev_r  <= bank_status;
            chk_armed_r <= 1'b1;
        end
    end

    always_comb begin
        for (int i = 0; i < AIL_NUM_BANKS; i++) begin
            chk_rise[i] = bank_status[i] & ~chk_prev_r[i];
            chk_fall[i] = ~bank_status[i] & chk_prev_r[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    int_follows_a: assert property (##1 int_req == $past(|bank_pend))
        else $error("interrupt lead does not follow unmasked requests");

    int_masked_a: assert property ((bank_pend == '0) ##1 (bank_pend == '0) |-> !int_req)
        else $error("interrupt raised with all requests masked");

    ds3_rise_a: assert property (
        edge_ctl_r[AIL_RISE_BIT] && $rose(alarm_rt[0]) && !$past(sys_rst)
        |=> bank_req[AIL_DS3_BANK][0])
        else $error("ds3 signal loss entry did not set its request");

    ds3_fall_a: assert property (
        edge_ctl_r[AIL_FALL_BIT] && $fell(alarm_rt[0]) && !$past(sys_rst)
        |=> bank_req[AIL_DS3_BANK][0])
        else $error("ds3 signal loss exit did not set its request");

    read_data_a: assert property (
        cpu_rd && bank_hit[AIL_DS3_BANK] |=> cpu_rdata == $past(bank_req[AIL_DS3_BANK]))
        else $error("read returned wrong request value");

    // width register lags the strap by one edge; the reset edge itself is excused
    wide_strap_a: assert property (##1 ($past(sys_rst) || counter_wide == !$past(compat_sel)))
        else $error("counter width does not follow compat select");

    latched_hold_a: assert property (
        !rd_latched && (latched_r != 8'h00) |=> (latched_r & $past(latched_r)) == $past(latched_r))
        else $error("latched alarm copy dropped without a read");

    latched_set_a: assert property (
        !sys_rst && alarm_rt != 8'h00 |=> (latched_r & $past(alarm_rt)) == $past(alarm_rt))
        else $error("alarm level did not reach the latched copy");

    latched_clear_a: assert property (!sys_rst && rd_latched |=> latched_r == $past(alarm_rt))
        else $error("latched copy not cleared by its read");

    latched_read_a: assert property (!sys_rst && rd_latched |=> cpu_rdata == $past(latched_r))
        else $error("latched copy read returned wrong bits");

    rt_read_a: assert property (
        !sys_rst && cpu_rd && cpu_addr == AIL_REALTIME_ALARM_STATUS |=> cpu_rdata == $past(alarm_rt))
        else $error("real-time status read returned wrong bits");

    fifo_read_a: assert property (!sys_rst && dl_fifo_pop |=> cpu_rdata == $past(dl_fifo_data))
        else $error("fifo port read returned wrong byte");

    rdata_hold_a: assert property (!cpu_rd |=> $stable(cpu_rdata))
        else $error("read data moved without a read");

    // the edge controls steer every condition bank, so a stray write is worth catching
    edge_write_a: assert property (
        !sys_rst && cpu_wr && cpu_addr == AIL_EDGE_CONTROL |=> edge_ctl_r == $past(cpu_wdata[1:0]))
        else $error("edge control write did not land");

    edge_hold_a: assert property (!(cpu_wr && cpu_addr == AIL_EDGE_CONTROL) |=> $stable(edge_ctl_r))
        else $error("edge control changed without a write");

    edge_read_a: assert property (
        !sys_rst && cpu_rd && cpu_addr == AIL_EDGE_CONTROL
        |=> cpu_rdata == {5'h00, $past(wide_r), $past(edge_ctl_r)})
        else $error("edge control read returned wrong bits");

    for (genvar g = 0; g < AIL_NUM_BANKS; g++) begin : chk_g
        bank_read_a: assert property (
            !sys_rst && cpu_rd && bank_hit[g] |=> cpu_rdata == $past(bank_req[g]))
            else $error("request read returned wrong bits");

        // a read with no status change in its cycle must leave the bank empty
        bank_clear_a: assert property (
            cpu_rd && bank_hit[g] && chk_rise[g] == 8'h00 && chk_fall[g] == 8'h00 |=> bank_req[g] == 8'h00)
            else $error("request bits survived a read");

        mask_write_a: assert property (!sys_rst && cpu_wr && mask_hit[g] |=> mask_r[g] == $past(cpu_wdata))
            else $error("mask write did not land");

        mask_hold_a: assert property (!(cpu_wr && mask_hit[g]) |=> $stable(mask_r[g]))
            else $error("mask changed without a write");

        if (g == AIL_DATALINK_BANK) begin : dl_g
            dl_entry_a: assert property (
                chk_armed_r |=> (bank_req[g] & $past(chk_rise[g])) == $past(chk_rise[g]))
                else $error("datalink entry did not set its request");

            dl_exit_a: assert property (
                chk_rise[g] == 8'h00 |=> (bank_req[g] & ~$past(bank_req[g])) == 8'h00)
                else $error("datalink request set without an entry");
        end else begin : cond_g
            cond_rise_a: assert property (
                chk_armed_r && edge_ctl_r[AIL_RISE_BIT]
                |=> (bank_req[g] & $past(chk_rise[g])) == $past(chk_rise[g]))
                else $error("condition entry did not set its request");

            cond_fall_a: assert property (
                chk_armed_r && edge_ctl_r[AIL_FALL_BIT]
                |=> (bank_req[g] & $past(chk_fall[g])) == $past(chk_fall[g]))
                else $error("condition exit did not set its request");

            cond_quiet_a: assert property (
                edge_ctl_r == 2'h0 |=> (bank_req[g] & ~$past(bank_req[g])) == 8'h00)
                else $error("condition request set with both edge controls off");
        end
    end

    int_raise_c: cover property (!int_req ##1 int_req);
    both_edges_c: cover property (edge_ctl_r == 2'h3 && bank_req[AIL_DS3_BANK] != 8'h00);
    dl_entry_c: cover property (bank_req[AIL_DATALINK_BANK] != 8'h00 && cpu_rd && bank_hit[AIL_DATALINK_BANK]);
    fifo_pop_c: cover property (dl_fifo_pop);

endmodule

// ---- test/ail_cpu_model.sv ----
`timescale 1ns/10ps
module ail_cpu_model
    import ail_pkg::*;
(
    input  wire logic       ref_clk,
    output logic      [5:0] cpu_addr,
    output logic            cpu_rd,
    output logic            cpu_wr,
    output ail_byte_t       cpu_wdata,
    input  wire logic [7:0] cpu_rdata
);
    initial begin
        cpu_addr  = 6'h3f;
        cpu_rd    = 1'b0;
        cpu_wr    = 1'b0;
        cpu_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////////
    // bus not held after the strobe: inverse shown so stale values never pass
    task automatic wr(input logic [5:0] a, input ail_byte_t d);
        @(posedge ref_clk);
        cpu_addr  <= a;
        cpu_wdata <= d;
        cpu_wr    <= 1'b1;
        @(posedge ref_clk);
        cpu_wr    <= 1'b0;
        cpu_addr  <= ~a;
        cpu_wdata <= ~d;
    endtask
    // reads come within a few cycles, far inside every service window
    task automatic rd(input logic [5:0] a, output ail_byte_t d);
        @(posedge ref_clk);
        cpu_addr <= a;
        cpu_rd   <= 1'b1;
        @(posedge ref_clk);
        cpu_rd   <= 1'b0;
        cpu_addr <= ~a;
        #1 d = cpu_rdata;
    endtask
endmodule

// ---- test/tb_ail_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin n_fail++; \
    $display("wrong value %s exp %h got %h", nm, ex, gt); end end
module tb_ail_top
    import ail_pkg::*;
;
    logic             ref_clk;
    logic             sys_rst;
    logic [5:0]       cpu_addr;
    logic             cpu_rd;
    logic             cpu_wr;
    ail_byte_t        cpu_wdata;
    logic [7:0]       cpu_rdata;
    logic             int_req;
    logic [7:0]       alarm_rt;
    logic [5:0][7:0]  cond_rt;
    logic [7:0]       path_maint_link_rt;
    logic [7:0]       dl_fifo_data;
    logic [7:0]       dl_msg_length;
    logic [7:0]       dl_fifo_depth;
    logic             dl_fifo_pop;
    logic             compat_sel;
    logic             counter_wide;
    int               n_fail;
    int               tests_run;
    int               n_pop;
    int               seed;
    ail_byte_t        d;
    ail_byte_t        src [8];
    ail_byte_t        acc [8];
    ail_byte_t        lat;
    logic             any;
    logic [1:0]       md;
    // cond banks 0..5, then the ds3 alarm bank, then the datalink bank
    localparam logic [5:0] ADDR_T [8] = '{AIL_LOOPBACK_REQUEST_ALL, AIL_LOOPBACK_REQUEST_DS3,
        AIL_LOOPBACK_REQUEST_MORE, AIL_FRAME_ERROR_REQUEST, AIL_DS2_FRAME_LOSS_REQUEST,
        AIL_COUNTER_SATURATION_REQ, AIL_DS3_STATUS_REQUEST, AIL_DATALINK_REQUEST};

    ail_top ail_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
        .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .int_req(int_req), .alarm_rt(alarm_rt),
        .cond_rt(cond_rt), .path_maint_link_rt(path_maint_link_rt), .dl_fifo_data(dl_fifo_data),
        .dl_msg_length(dl_msg_length), .dl_fifo_depth(dl_fifo_depth), .dl_fifo_pop(dl_fifo_pop),
        .compat_sel(compat_sel), .counter_wide(counter_wide));
    ail_cpu_model ail_cpu_model_inst (.ref_clk(ref_clk), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd),
        .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));
    ////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // pops counted at the edge that takes the read
    always @(posedge ref_clk) begin
        if (dl_fifo_pop === 1'b1)
            n_pop++;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        results();
    end
    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // datalink bank knows only entry; others follow the edge controls
    function automatic ail_byte_t exp_bits(input ail_byte_t o, input ail_byte_t n, input logic [1:0] m, int k);
        if (k == 7)
            return ~o & n;
        return ({8{m[0]}} & ~o & n) | ({8{m[1]}} & o & ~n);
    endfunction
    task automatic drive();
        @(posedge ref_clk);
        for (int k = 0; k < 6; k++)
            cond_rt[k] <= src[k];
        alarm_rt           <= src[6];
        path_maint_link_rt <= src[7];
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic rd_all();
        for (int k = 0; k < 8; k++)
            ail_cpu_model_inst.rd(ADDR_T[k], d);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'h26ac;
        n_fail = 0;
        tests_run = 0;
        n_pop = 0;
        sys_rst = 1'b1;
        alarm_rt = 8'h00;
        cond_rt = '0;
        path_maint_link_rt = 8'h00;
        dl_fifo_data = 8'h00;
        dl_msg_length = 8'h00;
        dl_fifo_depth = 8'h00;
        compat_sel = 1'b0;
        for (int k = 0; k < 8; k++)
            src[k] = 8'h00;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        `CHK("int_req", 1'b0, int_req)
        for (int i = 8'h25; i <= 8'h35; i++) begin
            ail_cpu_model_inst.rd(6'(i), d);
            `CHK("reset reg", 8'h00, d)
        end
        ail_cpu_model_inst.rd(AIL_EDGE_CONTROL, d);
        `CHK("edge ctl", 8'h04, d)
        ail_cpu_model_inst.rd(6'h3f, d);
        `CHK("unmapped", 8'h00, d)
        $display("test reset done");
        for (int i = 0; i < 8; i++)
            ail_cpu_model_inst.wr(AIL_REQUEST_MASK_BASE + 6'(i), 8'hff);
        for (int m = 0; m < 4; m++) begin
            md = 2'(m);
            for (int k = 0; k < 8; k++)
                src[k] = 8'h00;
            drive();
            ail_cpu_model_inst.wr(AIL_EDGE_CONTROL, {6'h00, md});
            rd_all();
            ail_cpu_model_inst.rd(AIL_LATCHED_ALARM_STATUS, d);
            lat = 8'h00;
            for (int k = 0; k < 8; k++)
                acc[k] = 8'h00;
            repeat (2) begin
                for (int k = 0; k < 8; k++) begin
                    d = 8'($random(seed));
                    acc[k] = acc[k] | exp_bits(src[k], d, md, k);
                    src[k] = d;
                end
                lat = lat | src[6];
                drive();
            end
            any = 1'b0;
            for (int k = 0; k < 8; k++)
                any = any | (|acc[k]);
            `CHK("int_req set", any, int_req)
            for (int k = 0; k < 8; k++) begin
                ail_cpu_model_inst.rd(ADDR_T[k], d);
                `CHK("request", acc[k], d)
            end
            ail_cpu_model_inst.rd(AIL_LATCHED_ALARM_STATUS, d);
            `CHK("latched", lat, d)
            repeat (2) @(posedge ref_clk);
            `CHK("int_req clr", 1'b0, int_req)
            for (int k = 0; k < 8; k++) begin
                ail_cpu_model_inst.rd(ADDR_T[k], d);
                `CHK("cleared", 8'h00, d)
            end
            $display("test edge mode %0d done", m);
        end
        for (int i = 0; i < 8; i++)
            ail_cpu_model_inst.wr(AIL_REQUEST_MASK_BASE + 6'(i), 8'h00);
        src[0] = ~src[0];
        drive();
        `CHK("masked", 1'b0, int_req)
        ail_cpu_model_inst.wr(AIL_REQUEST_MASK_BASE, 8'hff);
        repeat (2) @(posedge ref_clk);
        `CHK("unmasked", 1'b1, int_req)
        $display("test mask done");
        ail_cpu_model_inst.wr(AIL_EDGE_CONTROL, 8'h01);
        src[0] = 8'h00;
        drive();
        ail_cpu_model_inst.rd(ADDR_T[0], d);
        // entry lands in the very cycle the clearing read is taken
        fork
            ail_cpu_model_inst.rd(ADDR_T[0], d);
            begin
                @(posedge ref_clk);
                cond_rt[0] <= 8'hff;
            end
        join
        ail_cpu_model_inst.rd(ADDR_T[0], d);
        `CHK("set wins", 8'hff, d)
        $display("test collision done");
        @(posedge ref_clk);
        dl_fifo_data  <= 8'($random(seed));
        dl_msg_length <= 8'($random(seed));
        dl_fifo_depth <= 8'($random(seed));
        ail_cpu_model_inst.rd(AIL_DATALINK_RX_FIFO_PORT, d);
        `CHK("fifo port", dl_fifo_data, d)
        `CHK("fifo pop", 1, n_pop)
        ail_cpu_model_inst.rd(AIL_DATALINK_RX_MSG_LENGTH, d);
        `CHK("msg length", dl_msg_length, d)
        ail_cpu_model_inst.rd(AIL_DATALINK_RX_FIFO_DEPTH, d);
        `CHK("fifo depth", dl_fifo_depth, d)
        @(posedge ref_clk);
        compat_sel <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK("counter_wide", 1'b0, counter_wide)
        $display("test datalink and width done");
        results();
    end
endmodule
